/* rtl/cis_regs.sv */
// Summary, identity and event registers of the quad recovery device.
// Assumes a synchronous host port and sticky per-channel status inputs.
//
// The address-and-strobe port was left to the implementer.
`include "cis_defs.svh"

module cis_regs
  import cis_pkg::*;
#(
  parameter logic [15:0] PART_CODE = 16'h5A3C,  // Arbitrary value
  parameter logic [7:0]  REV_CODE  = 8'h07      // Arbitrary value
)
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  cis_pkg::cis_addr_t addr_i,
  input  cis_pkg::cis_byte_t wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output cis_pkg::cis_byte_t rdata_o,
  input  cis_pkg::cis_chan_t signal_absent_is_i,
  input  cis_pkg::cis_chan_t lock_lost_is_i,
  input  cis_pkg::cis_chan_t signal_absent_ie_i,
  input  cis_pkg::cis_chan_t lock_lost_ie_i,
  output cis_pkg::cis_chan_t chan_pending_o,
  output logic            soft_reset_o,
  output logic            irq_o
);
  import cis_pkg::*;

  cis_chan_t flags;
  cis_chan_t flags_d_reg;
  cis_chan_t evt_stat_reg;
  cis_chan_t evt_en_reg;
  cis_chan_t evt_clr;
  logic      soft_bit_d_reg;
  logic      soft_pulse_reg;
  logic      blk_rst;
  cis_byte_t rdata_reg;
  cis_byte_t rdata_next;

  // ****************************************
  // Decode helper
  // ****************************************
  function automatic logic hit(input cis_addr_t a, input cis_addr_t off);
    hit = (a == off);
  endfunction

  // ****************************************
  // Soft reset
  // ****************************************
  // Rising write of the bit gives a one-cycle reset; bit never stored
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      soft_bit_d_reg <= 1'b0;
      soft_pulse_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      soft_pulse_reg <= 1'b0;
      if (wr_i && hit(addr_i, `CIS_OFF_SOFT_RST))
      begin
        soft_bit_d_reg <= wdata_i[`CIS_SOFT_RST_BIT];
        soft_pulse_reg <= wdata_i[`CIS_SOFT_RST_BIT] & ~soft_bit_d_reg;
      end
      else
        soft_bit_d_reg <= 1'b0;
    end
  end

  assign blk_rst      = rst_i | soft_pulse_reg;
  assign soft_reset_o = soft_pulse_reg;

  // ****************************************
  // Channel flags
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `CIS_NUM_CHAN; g = g + 1)
    begin : g_chan
      cis_chan_flag u_flag
      (
        .mclk_i             (mclk_i),
        .rst_i              (blk_rst),
        .ce_i               (ce_i),
        .signal_absent_is_i (signal_absent_is_i[g]),
        .lock_lost_is_i     (lock_lost_is_i[g]),
        .signal_absent_ie_i (signal_absent_ie_i[g]),
        .lock_lost_ie_i     (lock_lost_ie_i[g]),
        .pending_o          (flags[g])
      );
    end
  endgenerate

  assign chan_pending_o = flags;

  // ****************************************
  // Event status, clear and enable
  // ****************************************
  assign evt_clr = (wr_i && hit(addr_i, `CIS_OFF_EVT_CLR)) ?
                   wdata_i[`CIS_NUM_CHAN-1:0] : '0;

  always_ff @(posedge mclk_i)
  begin
    if (blk_rst)
      flags_d_reg <= '0;
    else if (ce_i)
      flags_d_reg <= flags;
  end

  // Rising flag sets a sticky bit; set wins over a same-cycle clear
  always_ff @(posedge mclk_i)
  begin
    if (blk_rst)
      evt_stat_reg <= '0;
    else if (ce_i)
      evt_stat_reg <= (evt_stat_reg & ~evt_clr) | (flags & ~flags_d_reg);
  end

  always_ff @(posedge mclk_i)
  begin
    if (blk_rst)
      evt_en_reg <= '0;
    else if (ce_i && wr_i && hit(addr_i, `CIS_OFF_EVT_EN))
      evt_en_reg <= wdata_i[`CIS_NUM_CHAN-1:0];
  end

  assign irq_o = |(evt_stat_reg & evt_en_reg);

  // ****************************************
  // Read path
  // ****************************************
  always_comb
  begin
    rdata_next = `CIS_ZERO_BYTE;
    case (addr_i)
      `CIS_OFF_SUMMARY:  rdata_next = {{(`CIS_DATA_W-`CIS_NUM_CHAN){1'b0}}, flags};
      `CIS_OFF_PART_HI:  rdata_next = PART_CODE[15:8];
      `CIS_OFF_PART_LO:  rdata_next = PART_CODE[7:0];
      `CIS_OFF_REV_HI:   rdata_next = `CIS_REV_HI_VAL;
      `CIS_OFF_REV_LO:   rdata_next = REV_CODE;
      `CIS_OFF_EVT_STAT: rdata_next = {{(`CIS_DATA_W-`CIS_NUM_CHAN){1'b0}}, evt_stat_reg};
      `CIS_OFF_EVT_EN:   rdata_next = {{(`CIS_DATA_W-`CIS_NUM_CHAN){1'b0}}, evt_en_reg};
      default:           rdata_next = `CIS_ZERO_BYTE;
    endcase
  end

  // Writes to read-only offsets have no decode and are dropped
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rdata_reg <= `CIS_ZERO_BYTE;
    else if (ce_i)
      rdata_reg <= rd_i ? rdata_next : `CIS_ZERO_BYTE;
  end

  assign rdata_o = rdata_reg;
endmodule

/* rtl/cis_defs.svh */
// Constants for the channel summary and identity register bank.
// Assumes byte-wide registers on a plain address/strobe port.
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CIS_ADDR_W        8
`define CIS_OFF_SUMMARY   8'h01
`define CIS_OFF_PART_HI   8'h02
`define CIS_OFF_PART_LO   8'h03
`define CIS_OFF_REV_HI    8'h04
`define CIS_OFF_REV_LO    8'h05
`define CIS_OFF_EVT_STAT  8'h40
`define CIS_OFF_EVT_CLR   8'h41
`define CIS_OFF_EVT_EN    8'h42
`define CIS_OFF_SOFT_RST  8'h43

// ****************************************
// Values and fields
// ****************************************
`define CIS_DATA_W        8
`define CIS_NUM_CHAN      4
`define CIS_ZERO_BYTE     8'h00
`define CIS_REV_HI_VAL    8'h3E  // Arbitrary value
`define CIS_SOFT_RST_BIT  0

`endif

/* rtl/cis_pkg.sv */
// Types for the channel summary and identity register bank.
// Assumes cis_defs.svh is on the include path.
`include "cis_defs.svh"

package cis_pkg;
  typedef logic [`CIS_DATA_W-1:0] cis_byte_t;
  typedef logic [`CIS_ADDR_W-1:0] cis_addr_t;
  typedef logic [`CIS_NUM_CHAN-1:0] cis_chan_t;
endpackage

/* rtl/cis_chan_flag.sv */
// One channel's pending flag from its loss status bits and enables.
// Assumes the status inputs are sticky bits held by the channel logic.
`include "cis_defs.svh"

module cis_chan_flag
(
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic signal_absent_is_i,
  input  wire logic lock_lost_is_i,
  input  wire logic signal_absent_ie_i,
  input  wire logic lock_lost_ie_i,
  output logic      pending_o
);
  logic pending_next;

  // ****************************************
  // Flag evaluation
  // ****************************************
  always_comb
  begin
    pending_next = (signal_absent_is_i & signal_absent_ie_i) |
                   (lock_lost_is_i & lock_lost_ie_i);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      pending_o <= 1'b0;
    else if (ce_i)
      pending_o <= pending_next;
  end
endmodule

/* tb/cis_regs_props.sv */
// Checker for the summary and identity bank.
// Assumes binding to cis_regs; sees its ports only.
`include "cis_defs.svh"

module cis_regs_props
#(
  parameter logic [15:0] PART_CODE = 16'h5A3C,
  parameter logic [7:0]  REV_CODE  = 8'h07
)
(
  input wire logic         mclk_i,
  input wire logic         rst_i,
  input wire logic         ce_i,
  input cis_pkg::cis_addr_t addr_i,
  input wire logic         rd_i,
  input cis_pkg::cis_byte_t rdata_o,
  input cis_pkg::cis_chan_t signal_absent_is_i,
  input cis_pkg::cis_chan_t lock_lost_is_i,
  input cis_pkg::cis_chan_t signal_absent_ie_i,
  input cis_pkg::cis_chan_t lock_lost_ie_i,
  input cis_pkg::cis_chan_t chan_pending_o,
  input wire logic         soft_reset_o
);
  import cis_pkg::*;
  logic      rd_ok;
  cis_chan_t want;
  assign rd_ok = rd_i && ce_i;
  assign want = (signal_absent_is_i & signal_absent_ie_i) | (lock_lost_is_i & lock_lost_ie_i);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_sum; rd_ok && addr_i == 8'h01 |=> rdata_o[3:0] == $past(chan_pending_o); endproperty
  a_sum: assert property (p_sum) else $error("bad summary");
  property p_hi; rd_ok && addr_i == 8'h01 |=> rdata_o[7:4] == 4'h0; endproperty
  a_hi: assert property (p_hi) else $error("bad upper nibble");
  property p_flg; ce_i && !soft_reset_o |=> soft_reset_o || chan_pending_o == $past(want); endproperty
  a_flg: assert property (p_flg) else $error("bad flag");
  property p_id1; rd_ok && addr_i == 8'h02 |=> rdata_o == PART_CODE[15:8]; endproperty
  a_id1: assert property (p_id1) else $error("bad part high");
  property p_id0; rd_ok && addr_i == 8'h03 |=> rdata_o == PART_CODE[7:0]; endproperty
  a_id0: assert property (p_id0) else $error("bad part low");
  property p_rv1; rd_ok && addr_i == 8'h04 |=> rdata_o == `CIS_REV_HI_VAL; endproperty
  a_rv1: assert property (p_rv1) else $error("bad rev high");
  property p_rv0; rd_ok && addr_i == 8'h05 |=> rdata_o == REV_CODE; endproperty
  a_rv0: assert property (p_rv0) else $error("bad rev low");
  property p_clr; soft_reset_o |=> chan_pending_o == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("flags kept");
endmodule

bind cis_regs cis_regs_props #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) cis_regs_props_i (.*);

/* tb/cis_regs_tb_top.sv */
// Self-checking bench for the summary and identity bank.
// Assumes cis_regs and its checker compiled ahead.
`include "cis_defs.svh"

module cis_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cis_pkg::*;
  localparam logic [15:0] PART = 16'h3C96; // Arbitrary value
  localparam logic [7:0]  REV  = 8'h2B;    // Arbitrary value
  logic      mclk_i = 1'b0;
  logic      rst_i = 1'b1;
  logic      wr_i = 1'b0;
  logic      rd_i = 1'b0;
  cis_addr_t addr_i = 8'h00;
  cis_byte_t wdata_i = 8'h00;
  cis_chan_t sa_is = 4'h0, ll_is = 4'h0, sa_ie = 4'h0, ll_ie = 4'h0, pend;
  cis_byte_t rdata;
  logic      srst, irq;
  int        fails = 0, checks = 0;
  cis_regs #(.PART_CODE(PART), .REV_CODE(REV)) cis_regs_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .signal_absent_is_i(sa_is),
    .lock_lost_is_i(ll_is), .signal_absent_ie_i(sa_ie), .lock_lost_ie_i(ll_ie),
    .chan_pending_o(pend), .soft_reset_o(srst), .irq_o(irq));
  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, cis_byte_t e, cis_byte_t s);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(cis_addr_t a, cis_byte_t d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(cis_addr_t a, cis_byte_t e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic drive(cis_chan_t a, cis_chan_t b, cis_chan_t c, cis_chan_t d);
    @(posedge mclk_i);
    sa_is <= a;
    sa_ie <= b;
    ll_is <= c;
    ll_ie <= d;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic t_ident();
    for (int a = 1; a < 6; a++)
      wr(a[7:0], 8'hFF);
    rd(8'h01, 8'h00);
    rd(8'h02, PART[15:8]);
    rd(8'h03, PART[7:0]);
    rd(8'h04, `CIS_REV_HI_VAL);
    rd(8'h05, REV);
    rd(8'h7F, 8'h00);
  endtask
  task automatic t_flags();
    cis_chan_t m;
    wr(8'h42, 8'h0F);
    for (int c = 0; c < 4; c++)
    begin
      m = 4'h1 << c;
      drive(m, 4'h0, m, 4'h0);
      rd(8'h01, 8'h00);
      drive(m, m, 4'h0, 4'h0);
      rd(8'h01, {4'h0, m});
      chk("irq", 8'h01, {7'h00, irq});
      drive(4'h0, 4'h0, m, m);
      rd(8'h01, {4'h0, m});
      drive(4'h0, 4'h0, 4'h0, 4'h0);
      rd(8'h01, 8'h00);
      rd(8'h40, {4'h0, m});
      wr(8'h41, {4'h0, m});
      rd(8'h40, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
    end
  endtask
  task automatic t_srst();
    drive(4'hF, 4'hF, 4'h0, 4'h0);
    wr(8'h43, 8'h01);
    @(negedge mclk_i);
    chk("pulse", 8'h01, {7'h00, srst});
    rd(8'h42, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
  endtask
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk("pend", 8'h00, {4'h0, pend});
    t_ident();
    t_flags();
    t_srst();
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    give_verdict();
  end
endmodule
